// ===== src/line_tx_defs.svh
// constants for the transmit input gating of the line interface
// assumes inclusion by bare name from the design files
`ifndef LINE_TX_DEFS_SVH
`define LINE_TX_DEFS_SVH

// number of line channels
`define LTX_NUM_CHANNELS    2
// synchroniser depth for pins entering the ref_clk domain
`define LTX_SYNC_STAGES     2
// reset values
`define LTX_RST_BIT         1'h0
`define LTX_RST_PAIR        2'h0
// link clock period in ns, and in reference clock cycles at 100 MHz
`define LTX_LINK_PERIOD_NS  160
`define LTX_REF_PERIOD_NS   10
`define LTX_LINK_CYCLES     (`LTX_LINK_PERIOD_NS / `LTX_REF_PERIOD_NS)

`endif

// ===== src/line_tx_pkg.sv
// types shared by the transmit input gating files
// assumes nothing beyond a SystemVerilog compiler
package line_tx_pkg;

   // which edge of the transmit clock captures the rail data
   typedef enum logic {
      EDGE_FALLING,
      EDGE_RISING
   } edge_sel_t;

endpackage

// ===== src/rail_sampler.sv
// one channel's transmit clock edge finder and rail data capture
// assumes pins are asynchronous to ref_clk and the link clock is far slower
`timescale 1ns/1ns
`include "line_tx_defs.svh"

module rail_sampler (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   // pins from the terminal equipment
   input  wire logic                  clk_pin,
   input  wire logic                  pos_pin,
   input  wire logic                  neg_pin,
   // configuration
   input  wire line_tx_pkg::edge_sel_t edge_sel,
   // captured data
   output logic                       strobe_q,
   output logic                       pos_q,
   output logic                       neg_q
);
   import line_tx_pkg::*;

   logic clk_s1_q;
   logic clk_s2_q;
   logic clk_s3_q;
   logic pos_s1_q;
   logic pos_s2_q;
   logic neg_s1_q;
   logic neg_s2_q;
   logic rise_d;
   logic fall_d;
   logic take_d;

   // clock and data share the same synchroniser depth so they stay aligned
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clk_s1_q <= `LTX_RST_BIT;
         clk_s2_q <= `LTX_RST_BIT;
         clk_s3_q <= `LTX_RST_BIT;
         pos_s1_q <= `LTX_RST_BIT;
         pos_s2_q <= `LTX_RST_BIT;
         neg_s1_q <= `LTX_RST_BIT;
         neg_s2_q <= `LTX_RST_BIT;
      end else begin
         clk_s1_q <= clk_pin;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         pos_s1_q <= pos_pin;
         pos_s2_q <= pos_s1_q;
         neg_s1_q <= neg_pin;
         neg_s2_q <= neg_s1_q;
      end
   end

   // edge finder looks only at the second and third stages
   assign rise_d = clk_s2_q & ~clk_s3_q;
   assign fall_d = ~clk_s2_q & clk_s3_q;
   assign take_d = (edge_sel == EDGE_RISING) ? rise_d : fall_d;

   // both rails are taken on the same chosen edge
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         strobe_q <= `LTX_RST_BIT;
         pos_q    <= `LTX_RST_BIT;
         neg_q    <= `LTX_RST_BIT;
      end else begin
         strobe_q <= take_d;
         if (take_d) begin
            pos_q <= pos_s2_q;
            neg_q <= neg_s2_q;
         end
      end
   end

   a_fall_capture: assert property (@(posedge ref_clk) disable iff (reset)
      (edge_sel == EDGE_FALLING) && $fell(clk_s2_q) |=> strobe_q && pos_q == $past(pos_s2_q))
      else $error("falling edge did not capture positive rail");

   a_rise_capture: assert property (@(posedge ref_clk) disable iff (reset)
      (edge_sel == EDGE_RISING) && $rose(clk_s2_q) |=> strobe_q && neg_q == $past(neg_s2_q))
      else $error("rising edge did not capture negative rail");

   a_strobe_cause: assert property (@(posedge ref_clk) disable iff (reset)
      strobe_q |-> ($past(edge_sel) == EDGE_RISING) ? $past(rise_d) : $past(fall_d))
      else $error("capture strobe without the selected edge");

endmodule

// ===== src/line_tx_input_gating.sv
// transmit input gating of a multi channel line interface
// assumes terminal equipment logic drives the transmit clock and rails;
// the enable and clock invert pins are asynchronous, the enable bits and
// rail mode bits come from configuration logic on ref_clk
//
// Overview of operation
// - A channel's transmitter is on only when its enable bit and the enable pin are both 1.
// - Data is taken on the falling transmit clock edge by default, the source changes it on the rising edge.
// - In dual rail both rails are sampled on the selected active edge, falling or rising.
// - In single rail the negative rail is ignored and the source keeps it grounded.
// - In hardware mode a high clock invert pin moves every channel to rising edge sampling.
`timescale 1ns/1ns
`include "line_tx_defs.svh"

module line_tx_input_gating #(
   parameter int NUM_CHANNELS = `LTX_NUM_CHANNELS
) (
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    reset,
   // device wide pins
   input  wire logic                    transmitter_enable,
   input  wire logic                    transmit_clock_invert,
   input  wire logic                    hardware_mode,
   // per channel configuration from on chip logic
   input  wire logic [NUM_CHANNELS-1:0] transmitter_enable_bit,
   input  wire logic [NUM_CHANNELS-1:0] single_rail_mode,
   input  wire logic [NUM_CHANNELS-1:0] host_edge_rising,
   // per channel pins from the terminal equipment
   input  wire logic [NUM_CHANNELS-1:0] transmit_clock_in,
   input  wire logic [NUM_CHANNELS-1:0] positive_rail_data_in,
   input  wire logic [NUM_CHANNELS-1:0] negative_rail_data_in,
   // line driver controls
   output logic      [NUM_CHANNELS-1:0] line_out_plus,
   output logic      [NUM_CHANNELS-1:0] line_out_plus_oe,
   output logic      [NUM_CHANNELS-1:0] line_out_minus,
   output logic      [NUM_CHANNELS-1:0] line_out_minus_oe,
   // status
   output logic      [NUM_CHANNELS-1:0] transmitter_active,
   output logic      [NUM_CHANNELS-1:0] edge_rising_status,
   output logic      [NUM_CHANNELS-1:0] data_strobe
);
   import line_tx_pkg::*;

   logic                    en_s1_q;
   logic                    en_s2_q;
   logic                    inv_s1_q;
   logic                    inv_s2_q;
   logic                    hw_s1_q;
   logic                    hw_s2_q;
   logic [NUM_CHANNELS-1:0] on_d;
   logic [NUM_CHANNELS-1:0] on_q;
   logic [NUM_CHANNELS-1:0] rise_sel_d;
   logic [NUM_CHANNELS-1:0] rise_sel_q;
   logic [NUM_CHANNELS-1:0] strobe_w;
   logic [NUM_CHANNELS-1:0] pos_w;
   logic [NUM_CHANNELS-1:0] neg_w;
   logic [NUM_CHANNELS-1:0] plus_d;
   logic [NUM_CHANNELS-1:0] plus_q;
   logic [NUM_CHANNELS-1:0] minus_d;
   logic [NUM_CHANNELS-1:0] minus_q;
   logic [NUM_CHANNELS-1:0] strobe_q;

   // device wide pins are asynchronous, so each gets two flops first
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         en_s1_q  <= `LTX_RST_BIT;
         en_s2_q  <= `LTX_RST_BIT;
         inv_s1_q <= `LTX_RST_BIT;
         inv_s2_q <= `LTX_RST_BIT;
         hw_s1_q  <= `LTX_RST_BIT;
         hw_s2_q  <= `LTX_RST_BIT;
      end else begin
         en_s1_q  <= transmitter_enable;
         en_s2_q  <= en_s1_q;
         inv_s1_q <= transmit_clock_invert;
         inv_s2_q <= inv_s1_q;
         hw_s1_q  <= hardware_mode;
         hw_s2_q  <= hw_s1_q;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
         edge_sel_t edge_w;

         // transmitter on only for bit high and pin high, all other cases off
         assign on_d[ch] = transmitter_enable_bit[ch] & en_s2_q;

         // hardware mode takes the invert pin for all channels, host mode the
         // per channel bit; default of both is the falling edge
         assign rise_sel_d[ch] = hw_s2_q ? inv_s2_q : host_edge_rising[ch];

         assign edge_w = rise_sel_q[ch] ? EDGE_RISING : EDGE_FALLING;

         rail_sampler u_sampler (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .clk_pin  (transmit_clock_in[ch]),
            .pos_pin  (positive_rail_data_in[ch]),
            .neg_pin  (negative_rail_data_in[ch]),
            .edge_sel (edge_w),
            .strobe_q (strobe_w[ch]),
            .pos_q    (pos_w[ch]),
            .neg_q    (neg_w[ch])
         );

         // positive line pulse follows the captured rail while on; an off
         // channel drives nothing so a redundant mate can own the line
         always_comb begin
            if (!on_d[ch]) begin
               plus_d[ch] = 1'h0;
            end else if (strobe_w[ch]) begin
               plus_d[ch] = pos_w[ch];
            end else begin
               plus_d[ch] = plus_q[ch];
            end
         end

         // single rail forces the minus side quiet whatever the pin carries,
         // so a source that fails to ground the rail cannot upset the line
         always_comb begin
            if (!on_d[ch] || single_rail_mode[ch]) begin
               minus_d[ch] = 1'h0;
            end else if (strobe_w[ch]) begin
               minus_d[ch] = neg_w[ch];
            end else begin
               minus_d[ch] = minus_q[ch];
            end
         end

         a_enable_gate: assert property (@(posedge ref_clk) disable iff (reset)
            !transmitter_enable_bit[ch] || !en_s2_q |=> !line_out_plus_oe[ch]
               && !line_out_minus_oe[ch])
            else $error("transmitter on without both bit and pin");

         a_enable_on: assert property (@(posedge ref_clk) disable iff (reset)
            transmitter_enable_bit[ch] && en_s2_q |=> line_out_plus_oe[ch]
               && line_out_minus_oe[ch] && transmitter_active[ch])
            else $error("transmitter off with bit and pin high");

         a_off_quiet: assert property (@(posedge ref_clk) disable iff (reset)
            !line_out_plus_oe[ch] |-> !line_out_plus[ch] && !line_out_minus[ch]
               && !line_out_minus_oe[ch])
            else $error("line driven while transmitter off");

         a_single_rail: assert property (@(posedge ref_clk) disable iff (reset)
            single_rail_mode[ch] |=> !line_out_minus[ch])
            else $error("negative rail reached line in single rail");

         a_hw_invert: assert property (@(posedge ref_clk) disable iff (reset)
            hw_s2_q && inv_s2_q |=> edge_rising_status[ch])
            else $error("clock invert did not select rising edge");

         a_default_fall: assert property (@(posedge ref_clk) disable iff (reset)
            !host_edge_rising[ch] && !inv_s2_q |=> !edge_rising_status[ch])
            else $error("falling edge not kept by default");

         a_plus_follows: assert property (@(posedge ref_clk) disable iff (reset)
            strobe_w[ch] && on_d[ch] |=> line_out_plus[ch] == $past(pos_w[ch]))
            else $error("positive line out missed captured data");

         a_minus_follows: assert property (@(posedge ref_clk) disable iff (reset)
            strobe_w[ch] && on_d[ch] && !single_rail_mode[ch] |=> line_out_minus[ch]
               == $past(neg_w[ch]))
            else $error("negative line out missed captured data");

         a_plus_holds: assert property (@(posedge ref_clk) disable iff (reset)
            on_d[ch] && !strobe_w[ch] |=> $stable(line_out_plus[ch]))
            else $error("positive line out moved without a capture");

         a_host_edge: assert property (@(posedge ref_clk) disable iff (reset)
            !hw_s2_q |=> edge_rising_status[ch] == $past(host_edge_rising[ch]))
            else $error("host edge choice not applied");

         a_hw_fall: assert property (@(posedge ref_clk) disable iff (reset)
            hw_s2_q && !inv_s2_q |=> !edge_rising_status[ch])
            else $error("hardware mode left falling edge without invert");

         a_strobe_on: assert property (@(posedge ref_clk) disable iff (reset)
            data_strobe[ch] |-> transmitter_active[ch])
            else $error("capture reported while transmitter off");
      end
   endgenerate

   // edge choice is held in a flop so a pin change never splits one capture
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rise_sel_q <= '0;
      end else begin
         rise_sel_q <= rise_sel_d;
      end
   end

   // transmitter state and line driver enables
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         on_q <= '0;
      end else begin
         on_q <= on_d;
      end
   end

   // line data flops
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         plus_q   <= '0;
         minus_q  <= '0;
         strobe_q <= '0;
      end else begin
         plus_q   <= plus_d;
         minus_q  <= minus_d;
         strobe_q <= strobe_w & on_d;
      end
   end

   // outputs straight from flops; enable high means the pin is driven
   assign line_out_plus      = plus_q;
   assign line_out_minus     = minus_q;
   assign line_out_plus_oe   = on_q;
   assign line_out_minus_oe  = on_q;
   assign transmitter_active = on_q;
   assign edge_rising_status = rise_sel_q;
   assign data_strobe        = strobe_q;

endmodule

// ===== bench/tx_framer_model.sv
// far side model: terminal equipment driving one channel's clock and rails
// assumes the bench sets run, the data change edge and the rail mode
`timescale 1ns/1ns

module tx_framer_model (
   // control from the bench
   input  wire logic run,
   input  wire logic chg_on_fall,
   input  wire logic single_rail,
   input  wire logic neg_noise,
   // pins toward the device
   output logic      clk_o,
   output logic      pos_o,
   output logic      neg_o
);
   logic [3:0] cnt_q = 4'h0;

   // 160 ns link clock, parked low between frames
   initial clk_o = 1'h0;
   always #80 clk_o = run ? ~clk_o : 1'h0;

   // data moves only on the edge opposite the sampling edge
   always @(clk_o) if (clk_o != chg_on_fall) cnt_q <= cnt_q + 4'h1;
   assign pos_o = cnt_q[0] ^ cnt_q[2];
   // grounded in single rail, unless told to misbehave
   assign neg_o = (single_rail && !neg_noise) ? 1'h0 : cnt_q[1];
endmodule

// ===== bench/line_tx_input_gating_test.sv
// self checking bench for the transmit input gating block
// assumes the two channel default and one framer model per channel
`timescale 1ns/1ns

module line_tx_input_gating_test;
   logic       ref_clk   = 1'h0;
   logic       reset     = 1'h1;
   logic       tx_en     = 1'h0;
   logic       inv       = 1'h0;
   logic       hw        = 1'h0;
   logic       run       = 1'h0;
   logic       chg       = 1'h0;
   logic       noise     = 1'h0;
   logic [1:0] en_bit    = 2'h0;
   logic [1:0] single    = 2'h0;
   logic [1:0] host_rise = 2'h0;
   // each bit has its own framer model driving it
   wire  [1:0] tclk, pos, neg;
   logic [1:0] plus, plus_oe, minus, minus_oe, active, rise_st, strobe;
   logic       f_pos, f_neg, r_pos, r_neg;
   int         err_count = 0;
   int         n_checks  = 0;

   // reference clock, 100 MHz
   always #5 ref_clk = ~ref_clk;

   line_tx_input_gating #(.NUM_CHANNELS(2)) dut (
      .ref_clk(ref_clk), .reset(reset), .transmitter_enable(tx_en),
      .transmit_clock_invert(inv), .hardware_mode(hw), .transmitter_enable_bit(en_bit),
      .single_rail_mode(single), .host_edge_rising(host_rise), .transmit_clock_in(tclk),
      .positive_rail_data_in(pos), .negative_rail_data_in(neg), .line_out_plus(plus),
      .line_out_plus_oe(plus_oe), .line_out_minus(minus), .line_out_minus_oe(minus_oe),
      .transmitter_active(active), .edge_rising_status(rise_st), .data_strobe(strobe));
   tx_framer_model fr0 (.run(run), .chg_on_fall(chg), .single_rail(single[0]),
      .neg_noise(noise), .clk_o(tclk[0]), .pos_o(pos[0]), .neg_o(neg[0]));
   tx_framer_model fr1 (.run(run), .chg_on_fall(chg), .single_rail(single[1]),
      .neg_noise(noise), .clk_o(tclk[1]), .pos_o(pos[1]), .neg_o(neg[1]));

   // rail values at each channel 0 clock edge, the expected capture
   always @(negedge tclk[0]) begin
      f_pos <= pos[0];
      f_neg <= neg[0];
   end
   always @(posedge tclk[0]) begin
      r_pos <= pos[0];
      r_neg <= neg[0];
   end

   task automatic check(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD at %0t: saw %b expected %b", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // settle just past an edge so registered outputs have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // bounded wait for a channel 0 capture pulse
   task automatic wait_strobe();
      int k;
      k = 0;
      while (strobe[0] !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      if (k == 40) begin
         err_count++;
         end_of_test();
      end
   endtask

   // all four bit and pin pairs, plus one channel on alone
   task automatic enable_table();
      for (int v = 0; v < 5; v++) begin
         @(posedge ref_clk);
         en_bit <= (v == 4) ? 2'h1 : {2{v[1]}};
         tx_en  <= v[0] | v[2];
         cyc(8);
         check(active, (v == 4) ? 2'h1 : {2{v == 3}});
         check({plus_oe[0], minus_oe[0]}, {2{v == 3 || v == 4}});
         if (v < 3) check(strobe | plus | minus, 2'h0);
      end
      @(posedge ref_clk);
      en_bit <= 2'h3;
      cyc(2);
   endtask

   // new edge and rail setup, then one and a half link periods (24 reference cycles) to settle
   task automatic cfg(input logic h, input logic i, input logic [1:0] hr,
                      input logic [1:0] s, input logic c, input logic nz);
      @(posedge ref_clk);
      hw        <= h;
      inv       <= i;
      host_rise <= hr;
      single    <= s;
      chg       <= c;
      noise     <= nz;
      cyc(24);
   endtask

   // four symbols must match the rails at the selected edge
   // both framers run in lock step, so channel 1 must show the same symbols
   task automatic captures(input logic rise);
      logic [1:0] want;
      for (int i = 0; i < 4; i++) begin
         cyc(1);
         wait_strobe();
         want = rise ? {r_neg, r_pos} : {f_neg, f_pos};
         check({minus[0], plus[0]}, want & {!single[0], 1'h1});
         check({minus[1], plus[1]}, want & {!single[1], 1'h1});
         check(strobe, 2'h3);
      end
      check(rise_st, {rise, rise});
   endtask

   // reset spans two edges; outputs are looked at after they settle
   initial begin
      @(posedge ref_clk);
      #1;
      check(active | plus_oe | minus_oe | strobe, 2'h0);
      @(posedge ref_clk);
      reset <= 1'h0;
      run   <= 1'h1;
      enable_table();
      cfg(1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0);
      captures(1'h0);
      cfg(1'h0, 1'h0, 2'h3, 2'h0, 1'h1, 1'h0);
      captures(1'h1);
      cfg(1'h0, 1'h0, 2'h0, 2'h3, 1'h0, 1'h1);
      captures(1'h0);
      cfg(1'h1, 1'h1, 2'h0, 2'h0, 1'h1, 1'h0);
      captures(1'h1);
      cfg(1'h1, 1'h0, 2'h3, 2'h0, 1'h0, 1'h0);
      captures(1'h0);
      end_of_test();
   end

   // hang guard
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end
endmodule
